// >>> hw/monitor_setup_pkg.sv
// Package with register offsets, field positions and reset values of the monitor setup block.
package monitor_setup_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CONV_W = 8;
    localparam int TEMP_W = 8;
    localparam logic [7:0] HYST_FILTER_CTRL_OFFSET = 8'hbc;
    localparam logic [7:0] TACH_MODE_RES_CTRL_OFFSET = 8'hbd;
    localparam logic [7:0] HYST_FILTER_CTRL_RESET = 8'h00;
    localparam logic [7:0] TACH_MODE_RES_CTRL_RESET = 8'h00;
    localparam logic [7:0] HYST_FILTER_CTRL_MASK = 8'h7f;
    localparam logic [7:0] TACH_MODE_RES_CTRL_MASK = 8'h3f;
    localparam int VH_LSB = 0;
    localparam int VH_MSB = 2;
    localparam int ZONE1_LIMIT_FILTER_BIT = 3;
    localparam int ZONE2_LIMIT_FILTER_BIT = 4;
    localparam int ZONE1_FAN_FILTER_BIT = 5;
    localparam int ZONE2_FAN_FILTER_BIT = 6;
    localparam int TACH_SMART_LSB = 0;
    localparam int TACH_SMART_MSB = 3;
    localparam int ZONES_A_HALF_BIT = 4;
    localparam int ZONES_B_HALF_BIT = 5;
endpackage

// >>> hw/voltage_window_check.sv
// One voltage channel comparator with hysteresis on leaving an error condition.
`timescale 1ns/10ps
`default_nettype none
module voltage_window_check #(
    parameter int CONV_W = 8
) (
    input wire logic sys_clk, // System clock.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic sample_valid, // New reading present.
    input wire logic [CONV_W-1:0] reading, // Converter reading.
    input wire logic [CONV_W-1:0] low_limit, // Low limit.
    input wire logic [CONV_W-1:0] high_limit, // High limit.
    input wire logic [2:0] voltage_hysteresis, // Hysteresis in converter steps.
    output logic error_set // One-cycle pulse while a violation persists.
);
    logic high_viol_reg;
    logic low_viol_reg;
    logic [CONV_W:0] high_release;
    logic [CONV_W:0] low_release;
    logic high_viol_next;
    logic low_viol_next;

    // Release points are widened by one bit so a high-side borrow shows in the top bit instead of being lost.
    always_comb begin
        high_release = {1'b0, high_limit} - {{(CONV_W - 2){1'b0}}, voltage_hysteresis};
        low_release = {1'b0, low_limit} + {{(CONV_W - 2){1'b0}}, voltage_hysteresis};
        // hold until back inside by hysteresis
        // A high limit below the hysteresis leaves no release point, so the violation holds.
        high_viol_next = (reading > high_limit)
            || (high_viol_reg && (high_release[CONV_W] || ({1'b0, reading} > high_release)));
        low_viol_next = (reading < low_limit)
            || (low_viol_reg && ({1'b0, reading} < low_release));
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            high_viol_reg <= 1'b0;
            low_viol_reg <= 1'b0;
            error_set <= 1'b0;
        end else if (sample_valid) begin
            high_viol_reg <= high_viol_next;
            low_viol_reg <= low_viol_next;
            error_set <= high_viol_next || low_viol_next;
        end else begin
            error_set <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> hw/monitor_special_function_setup.sv
// Setup registers for voltage hysteresis, temperature filter selection and tach mode.
`timescale 1ns/10ps
`default_nettype none
module monitor_special_function_setup #(
    parameter int CONV_W = monitor_setup_pkg::CONV_W,
    parameter int TEMP_W = monitor_setup_pkg::TEMP_W
) (
    input wire logic sys_clk, // System clock, 10 MHz.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic reg_wr, // Host port register write strobe.
    input wire logic [7:0] reg_addr, // Host port register address.
    input wire logic [7:0] reg_wdata, // Host port write data.
    output logic [7:0] reg_rdata, // Read data for reg_addr.
    output logic reg_hit, // Address selects one of these registers.
    input wire logic sample_valid, // Voltage sample strobe.
    input wire logic [CONV_W-1:0] voltage_reading, // Voltage channel reading.
    input wire logic [CONV_W-1:0] voltage_low_limit, // Voltage low limit.
    input wire logic [CONV_W-1:0] voltage_high_limit, // Voltage high limit.
    output logic voltage_error_set, // Pulse that sets the channel error bit.
    input wire logic [TEMP_W-1:0] zone1_raw_temp, // Zone 1 unfiltered temperature.
    input wire logic [TEMP_W-1:0] zone1_smooth_temp, // Zone 1 spike-smoothed temperature.
    input wire logic [TEMP_W-1:0] zone2_raw_temp, // Zone 2 unfiltered temperature.
    input wire logic [TEMP_W-1:0] zone2_smooth_temp, // Zone 2 spike-smoothed temperature.
    output logic [TEMP_W-1:0] zone1_limit_temp, // Zone 1 temperature for limit checks.
    output logic [TEMP_W-1:0] zone2_limit_temp, // Zone 2 temperature for limit checks.
    output logic [TEMP_W-1:0] zone1_fan_temp, // Zone 1 temperature for fan control.
    output logic [TEMP_W-1:0] zone2_fan_temp, // Zone 2 temperature for fan control.
    output logic [2:0] voltage_hysteresis, // Current hysteresis setting.
    output logic [3:0] tach_smart_en, // Smart tach enables, tach 1 in bit 0.
    output logic zones_a_half_degree, // Half-degree resolution, zones 1 and 2.
    output logic zones_b_half_degree // Half-degree resolution, zones 3 and 4.
);
    logic [7:0] hyst_filter_ctrl_reg;
    logic [7:0] hyst_filter_ctrl_next;
    logic [7:0] tach_mode_res_ctrl_reg;
    logic [7:0] tach_mode_res_ctrl_next;
    logic hyst_filter_ctrl_sel;
    logic tach_mode_res_ctrl_sel;
    logic zone1_limit_filter_sel;
    logic zone2_limit_filter_sel;
    logic zone1_fan_filter_sel;
    logic zone2_fan_filter_sel;
    logic tach1_smart_en;
    logic tach2_smart_en;
    logic tach3_smart_en;
    logic tach4_smart_en;

    function automatic logic [TEMP_W-1:0] pick_temp(input logic sel,
                                                    input logic [TEMP_W-1:0] raw,
                                                    input logic [TEMP_W-1:0] smooth);
        pick_temp = sel ? smooth : raw;
    endfunction

    // Address compare shared by the write enables and the read mux.
    function automatic logic addr_selects(input logic [7:0] addr, input logic [7:0] offset);
        addr_selects = (addr == offset);
    endfunction

    // Reserved positions are cleared on the way in, so they can never read back as one
    // and nothing downstream can come to depend on them.
    function automatic logic [7:0] take_write(input logic take,
                                              input logic [7:0] current,
                                              input logic [7:0] wdata,
                                              input logic [7:0] keep_mask);
        take_write = take ? (wdata & keep_mask) : current;
    endfunction

    // One decode of the address feeds the write enables and the read mux alike.
    assign hyst_filter_ctrl_sel =
        addr_selects(reg_addr, monitor_setup_pkg::HYST_FILTER_CTRL_OFFSET);
    assign tach_mode_res_ctrl_sel =
        addr_selects(reg_addr, monitor_setup_pkg::TACH_MODE_RES_CTRL_OFFSET);

    always_comb begin
        hyst_filter_ctrl_next = take_write(reg_wr && hyst_filter_ctrl_sel,
                                           hyst_filter_ctrl_reg, reg_wdata,
                                           monitor_setup_pkg::HYST_FILTER_CTRL_MASK);
    end

    always_comb begin
        tach_mode_res_ctrl_next = take_write(reg_wr && tach_mode_res_ctrl_sel,
                                             tach_mode_res_ctrl_reg, reg_wdata,
                                             monitor_setup_pkg::TACH_MODE_RES_CTRL_MASK);
    end

    // Each register holds its value until a write selects it; back-to-back writes to
    // the same register are each taken.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            hyst_filter_ctrl_reg <= monitor_setup_pkg::HYST_FILTER_CTRL_RESET;
        end else begin
            hyst_filter_ctrl_reg <= hyst_filter_ctrl_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tach_mode_res_ctrl_reg <= monitor_setup_pkg::TACH_MODE_RES_CTRL_RESET;
        end else begin
            tach_mode_res_ctrl_reg <= tach_mode_res_ctrl_next;
        end
    end

    // The read port is combinational, so software sees a write from the next cycle on.
    // unmapped addresses read zero
    always_comb begin
        reg_hit = hyst_filter_ctrl_sel || tach_mode_res_ctrl_sel;
        reg_rdata = 8'h00;
        if (hyst_filter_ctrl_sel) begin
            reg_rdata = hyst_filter_ctrl_reg;
        end else if (tach_mode_res_ctrl_sel) begin
            reg_rdata = tach_mode_res_ctrl_reg;
        end
    end

    assign voltage_hysteresis =
        hyst_filter_ctrl_reg[monitor_setup_pkg::VH_MSB:monitor_setup_pkg::VH_LSB];

    // The smoothing filter and its zone enables sit outside this block; the selects only
    // mean what they say while software keeps those enables clear.
    // zone 1 limit select
    assign zone1_limit_filter_sel =
        hyst_filter_ctrl_reg[monitor_setup_pkg::ZONE1_LIMIT_FILTER_BIT];
    assign zone2_limit_filter_sel =
        hyst_filter_ctrl_reg[monitor_setup_pkg::ZONE2_LIMIT_FILTER_BIT];
    assign zone1_fan_filter_sel =
        hyst_filter_ctrl_reg[monitor_setup_pkg::ZONE1_FAN_FILTER_BIT];
    assign zone2_fan_filter_sel =
        hyst_filter_ctrl_reg[monitor_setup_pkg::ZONE2_FAN_FILTER_BIT];

    assign tach1_smart_en = tach_mode_res_ctrl_reg[monitor_setup_pkg::TACH_SMART_LSB];
    assign tach2_smart_en = tach_mode_res_ctrl_reg[monitor_setup_pkg::TACH_SMART_LSB + 1];
    assign tach3_smart_en = tach_mode_res_ctrl_reg[monitor_setup_pkg::TACH_SMART_LSB + 2];
    assign tach4_smart_en = tach_mode_res_ctrl_reg[monitor_setup_pkg::TACH_SMART_MSB];
    assign tach_smart_en = {tach4_smart_en, tach3_smart_en, tach2_smart_en, tach1_smart_en};

    assign zones_a_half_degree = tach_mode_res_ctrl_reg[monitor_setup_pkg::ZONES_A_HALF_BIT];
    assign zones_b_half_degree = tach_mode_res_ctrl_reg[monitor_setup_pkg::ZONES_B_HALF_BIT];

    // Selected temperatures are registered so consumers see a clean value each cycle.
    // zone 1 limit source
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            zone1_limit_temp <= '0;
        end else begin
            zone1_limit_temp <= pick_temp(
                zone1_limit_filter_sel,
                zone1_raw_temp, zone1_smooth_temp);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            zone2_limit_temp <= '0;
        end else begin
            zone2_limit_temp <= pick_temp(
                zone2_limit_filter_sel,
                zone2_raw_temp, zone2_smooth_temp);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            zone1_fan_temp <= '0;
        end else begin
            zone1_fan_temp <= pick_temp(
                zone1_fan_filter_sel,
                zone1_raw_temp, zone1_smooth_temp);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            zone2_fan_temp <= '0;
        end else begin
            zone2_fan_temp <= pick_temp(
                zone2_fan_filter_sel,
                zone2_raw_temp, zone2_smooth_temp);
        end
    end

    // A reading equal to a limit is inside it; only a strict crossing raises an error.
    // The error pulse repeats on each sample while a violation holds, so a clear made
    // before the reading recovers by the hysteresis is set again at the next sample.
    // error detection
    voltage_window_check #(
        .CONV_W(CONV_W)
    ) u_voltage_check (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .sample_valid(sample_valid),
        .reading(voltage_reading),
        .low_limit(voltage_low_limit),
        .high_limit(voltage_high_limit),
        .voltage_hysteresis(voltage_hysteresis),
        .error_set(voltage_error_set)
    );
endmodule
`default_nettype wire

// >>> testbench/monitor_setup_properties.sv
// Concurrent checks on the monitor setup block ports.
`timescale 1ns/10ps
`default_nettype none
module monitor_setup_properties (
    input wire logic sys_clk, // Clock.
    input wire logic rst_b, // Reset, active low.
    input wire logic reg_wr, // Write strobe.
    input wire logic [7:0] reg_addr, // Address.
    input wire logic [7:0] reg_wdata, // Write data.
    input wire logic [7:0] reg_rdata, // Read data.
    input wire logic sample_valid, // Sample strobe.
    input wire logic [7:0] voltage_reading, // Reading.
    input wire logic [7:0] voltage_low_limit, // Low limit.
    input wire logic [7:0] voltage_high_limit, // High limit.
    input wire logic voltage_error_set, // Error pulse.
    input wire logic [7:0] zone1_smooth_temp, // Smoothed zone 1.
    input wire logic [7:0] zone1_limit_temp, // Zone 1 limit input.
    input wire logic [7:0] zone1_fan_temp, // Zone 1 fan input.
    input wire logic [7:0] zone2_smooth_temp, // Smoothed zone 2.
    input wire logic [7:0] zone2_limit_temp, // Zone 2 limit input.
    input wire logic [7:0] zone2_fan_temp, // Zone 2 fan input.
    input wire logic [2:0] voltage_hysteresis, // Hysteresis.
    input wire logic [3:0] tach_smart_en, // Tach enables.
    input wire logic zones_a_half_degree, // Zones 1/2 resolution.
    input wire logic zones_b_half_degree // Zones 3/4 resolution.
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // A select write that is not overwritten on the next cycle.
    sequence s_sel(int b);
        reg_wr && reg_addr == 8'hbc && reg_wdata[b] ##1 !(reg_wr && reg_addr == 8'hbc);
    endsequence
    AST_HYST: assert property (reg_wr && reg_addr == 8'hbc |=>
        voltage_hysteresis == $past(reg_wdata[2:0])) else $error("hysteresis not taken");
    AST_LIM1: assert property (s_sel(3) |=>
        zone1_limit_temp == $past(zone1_smooth_temp)) else $error("zone 1 limit source");
    AST_FAN1: assert property (s_sel(5) |=>
        zone1_fan_temp == $past(zone1_smooth_temp)) else $error("zone 1 fan source");
    AST_LIM2: assert property (s_sel(4) |=>
        zone2_limit_temp == $past(zone2_smooth_temp)) else $error("zone 2 limit source");
    AST_FAN2: assert property (s_sel(6) |=>
        zone2_fan_temp == $past(zone2_smooth_temp)) else $error("zone 2 fan source");
    AST_TACH: assert property (reg_wr && reg_addr == 8'hbd |=>
        tach_smart_en == $past(reg_wdata[3:0])) else $error("tach enables");
    AST_RESOL: assert property (reg_wr && reg_addr == 8'hbd |=>
        {zones_b_half_degree, zones_a_half_degree} == $past(reg_wdata[5:4]))
        else $error("resolution bits");
    AST_RSV: assert property (!(reg_addr == 8'hbc && reg_rdata[7]) &&
        !(reg_addr == 8'hbd && reg_rdata[7:6] != 2'h0)) else $error("reserved bit set");
    AST_ERR: assert property (sample_valid && (voltage_reading > voltage_high_limit ||
        voltage_reading < voltage_low_limit) |=> voltage_error_set) else $error("error missed");
    AST_NOERR: assert property (sample_valid &&
        {1'b0, voltage_reading} + voltage_hysteresis <= {1'b0, voltage_high_limit} &&
        {1'b0, voltage_reading} >= {1'b0, voltage_low_limit} + voltage_hysteresis
        |=> !voltage_error_set) else $error("error inside window");
endmodule
`default_nettype wire

// >>> testbench/monitor_special_function_setup_test.sv
// Self-checking bench for the monitor setup block.
`timescale 1ns/10ps
`default_nettype none
module monitor_special_function_setup_test;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic reg_wr = 1'b0, sample_valid = 1'b0, reg_hit, voltage_error_set;
    logic zones_a_half_degree, zones_b_half_degree;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, voltage_reading = 8'h00;
    logic [7:0] voltage_low_limit = 8'd20, voltage_high_limit = 8'd100;
    logic [7:0] zone1_raw_temp = 8'h11, zone1_smooth_temp = 8'h33;
    logic [7:0] zone2_raw_temp = 8'h22, zone2_smooth_temp = 8'h44;
    logic [7:0] zone1_limit_temp, zone2_limit_temp, zone1_fan_temp, zone2_fan_temp;
    logic [2:0] voltage_hysteresis;
    logic [3:0] tach_smart_en;
    int n_mismatch = 0;
    int cmp_count = 0;
    always #50 sys_clk = ~sys_clk;
    monitor_special_function_setup monitor_special_function_setup_inst (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .reg_wr(reg_wr),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_hit(reg_hit),
        .sample_valid(sample_valid),
        .voltage_reading(voltage_reading),
        .voltage_low_limit(voltage_low_limit),
        .voltage_high_limit(voltage_high_limit),
        .voltage_error_set(voltage_error_set),
        .zone1_raw_temp(zone1_raw_temp),
        .zone1_smooth_temp(zone1_smooth_temp),
        .zone2_raw_temp(zone2_raw_temp),
        .zone2_smooth_temp(zone2_smooth_temp),
        .zone1_limit_temp(zone1_limit_temp),
        .zone2_limit_temp(zone2_limit_temp),
        .zone1_fan_temp(zone1_fan_temp),
        .zone2_fan_temp(zone2_fan_temp),
        .voltage_hysteresis(voltage_hysteresis),
        .tach_smart_en(tach_smart_en),
        .zones_a_half_degree(zones_a_half_degree),
        .zones_b_half_degree(zones_b_half_degree)
    );
    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        step();
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        step();
        reg_wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        step();
        reg_addr = a;
        #1;
        chk(exp, reg_rdata);
    endtask
    task automatic t_regs();
        rd_chk(8'hbc, 8'h00);
        chk(8'h01, {7'h0, reg_hit});
        rd_chk(8'hbd, 8'h00);
        wr(8'hbc, 8'hff);
        rd_chk(8'hbc, 8'h7f);
        chk(8'h07, {5'h0, voltage_hysteresis});
        wr(8'hbd, 8'hff);
        rd_chk(8'hbd, 8'h3f);
        wr(8'hbe, 8'h5a);
        rd_chk(8'hbe, 8'h00);
        chk(8'h00, {7'h0, reg_hit});
        rd_chk(8'hbd, 8'h3f);
        rd_chk(8'hbc, 8'h7f);
        for (int i = 0; i < 4; i++) begin
            wr(8'hbd, 8'h01 << i);
            chk(8'h01 << i, {4'h0, tach_smart_en});
        end
        for (int i = 0; i < 2; i++) begin
            wr(8'hbd, 8'h10 << i);
            chk(8'h01 << i, {6'h0, zones_b_half_degree, zones_a_half_degree});
        end
    endtask
    // the smoothing zone enables sit outside and stay clear, so the selects alone decide.
    // Index 4 shifts the select out, leaving all four on raw readings.
    task automatic t_temp();
        for (int i = 0; i < 5; i++) begin
            logic [3:0] sel;
            sel = 4'h1 << i;
            wr(8'hbc, {1'b0, sel, 3'h0});
            step();
            chk(sel[0] ? zone1_smooth_temp : zone1_raw_temp, zone1_limit_temp);
            chk(sel[1] ? zone2_smooth_temp : zone2_raw_temp, zone2_limit_temp);
            chk(sel[2] ? zone1_smooth_temp : zone1_raw_temp, zone1_fan_temp);
            chk(sel[3] ? zone2_smooth_temp : zone2_raw_temp, zone2_fan_temp);
        end
    endtask
    // Window 20..100 with a hysteresis of two steps on both sides.
    task automatic t_volt();
        logic [7:0] vs [7] = '{8'd101, 8'd99, 8'd98, 8'd60, 8'd19, 8'd21, 8'd22};
        logic [7:0] ex [7] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
        wr(8'hbc, 8'h02);
        for (int i = 0; i < 7; i++) begin
            sample_chk(vs[i], ex[i]);
        end
        // Software loosens the high limit past the hysteresis while the error holds.
        sample_chk(8'd101, 8'h01);
        voltage_high_limit = 8'd104;
        sample_chk(8'd101, 8'h00);
        voltage_high_limit = 8'd100;
        wr(8'hbc, 8'h00);
        sample_chk(8'd101, 8'h01);
        sample_chk(8'd100, 8'h00);
    endtask
    task automatic sample_chk(input logic [7:0] v, input logic [7:0] exp);
        step();
        sample_valid = 1'b1;
        voltage_reading = v;
        step();
        sample_valid = 1'b0;
        chk(exp, {7'h0, voltage_error_set});
    endtask
    // A reset in mid-run must clear both registers and the registered zone 1 fan temperature.
    task automatic t_reset();
        wr(8'hbc, 8'h7f);
        wr(8'hbd, 8'h3f);
        step();
        rst_b = 1'b0;
        #1;
        chk(8'h00, reg_rdata);
        chk(8'h00, {5'h0, voltage_hysteresis});
        chk(8'h00, {4'h0, tach_smart_en});
        chk(8'h00, zone1_fan_temp);
        step();
        rst_b = 1'b1;
        rd_chk(8'hbc, 8'h00);
        rd_chk(8'hbd, 8'h00);
        chk(zone1_raw_temp, zone1_fan_temp);
    endtask
    task automatic finish_test();
        $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        t_regs();
        t_temp();
        t_volt();
        t_reset();
        finish_test();
    end
    // The tests need about eighty cycles; a thousand means a hang.
    initial begin
        #100000;
        n_mismatch++;
        finish_test();
    end
endmodule
bind monitor_special_function_setup monitor_setup_properties monitor_setup_properties_inst (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .sample_valid(sample_valid),
    .voltage_reading(voltage_reading),
    .voltage_low_limit(voltage_low_limit),
    .voltage_high_limit(voltage_high_limit),
    .voltage_error_set(voltage_error_set),
    .zone1_smooth_temp(zone1_smooth_temp),
    .zone1_limit_temp(zone1_limit_temp),
    .zone1_fan_temp(zone1_fan_temp),
    .zone2_smooth_temp(zone2_smooth_temp),
    .zone2_limit_temp(zone2_limit_temp),
    .zone2_fan_temp(zone2_fan_temp),
    .voltage_hysteresis(voltage_hysteresis),
    .tach_smart_en(tach_smart_en),
    .zones_a_half_degree(zones_a_half_degree),
    .zones_b_half_degree(zones_b_half_degree)
);
`default_nettype wire
